// ---- gt16_pkg.sv ----
package gt16_pkg;

  localparam logic [7:0] GT16_OFF_CTRL = 8'h00;
  localparam logic [7:0] GT16_OFF_GATE = 8'h04;
  localparam logic [7:0] GT16_OFF_CNT_LO = 8'h08;
  localparam logic [7:0] GT16_OFF_CNT_HI = 8'h0c;
  localparam logic [7:0] GT16_OFF_FLAGS = 8'h10;
  localparam logic [7:0] GT16_OFF_IEN = 8'h14;
  localparam logic [7:0] GT16_OFF_IRQCTL = 8'h18;

  // Counter control register fields
  localparam int GT16_CTRL_ON = 0;
  localparam int GT16_CTRL_SYNCDIS = 2;
  localparam int GT16_CTRL_OSCEN = 3;
  localparam int GT16_CTRL_CS = 6;
  // Gate control register fields
  localparam int GT16_GATE_SRC = 0;
  localparam int GT16_GATE_VAL = 2;
  localparam int GT16_GATE_GO = 3;
  localparam int GT16_GATE_SPM = 4;
  localparam int GT16_GATE_TM = 5;
  localparam int GT16_GATE_POL = 6;
  localparam int GT16_GATE_EN = 7;
  // Flag and enable register fields
  localparam int GT16_FLAG_ROLL = 0;
  localparam int GT16_FLAG_GATE = 7;
  localparam int GT16_IRQ_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int GT16_IRQ_GIE = 7;

  localparam logic [1:0] GT16_SRC_PIN = 2'h0;
  localparam logic [1:0] GT16_SRC_WRAP8 = 2'h1;
  localparam logic [1:0] GT16_SRC_MATCH = 2'h2;
  localparam logic [1:0] GT16_CS_DIV4 = 2'h0;
  localparam logic [1:0] GT16_CS_SYS = 2'h1;
  localparam logic [1:0] GT16_CS_EXT = 2'h2;
  localparam logic [1:0] GT16_CS_LFOSC = 2'h3;

  localparam logic [7:0] GT16_RST_REG = 8'h00;
  localparam logic [15:0] GT16_RST_COUNT = 16'h0000;
  localparam logic [15:0] GT16_COUNT_MAX = 16'hffff;
  localparam logic [7:0] GT16_WRAP8_FROM = 8'hff;
  localparam logic [7:0] GT16_WRAP8_TO = 8'h00;
  localparam logic [1:0] GT16_DIV4_LAST = 2'h3;

  typedef enum logic [2:0] {
    GT16_SP_IDLE = 3'b001,
    GT16_SP_ARMED = 3'b010,
    GT16_SP_RUN = 3'b100
  } gt16_sp_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } gt16_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gt16_apb_rsp_s;

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic ext_prev;
    logic lf_prev;
    logic [1:0] div;
    logic [7:0] t0_prev;
    logic [7:0] t2_prev;
    logic t0_pulse;
    logic t2_pulse;
    logic src_prev;
    logic tff;
    logic active_prev;
    gt16_sp_e sp;
    logic gval;
    logic [15:0] count;
    logic [1:0] cs;
    logic oscen;
    logic syncdis;
    logic on;
    logic ge;
    logic pol;
    logic tm;
    logic spm;
    logic [1:0] src;
    logic roll_f;
    logic gate_f;
    logic roll_ie;
    logic gate_ie;
    logic peripheral_irq_enable;
    logic global_irq_enable;
    logic irq;
    logic wake;
    logic osc_run;
    gt16_apb_rsp_s rsp;
  } gt16_state_s;

endpackage

// ---- gt16_gate_timer.sv ----
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gt16_gate_timer
  import gt16_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire gt16_apb_req_s apb_req,
  output gt16_apb_rsp_s apb_rsp,
  input wire logic gate_input_pin,
  input wire logic ext_clock_pin,
  input wire logic secondary_osc_clock,
  input wire logic low_freq_internal_osc,
  input wire logic [7:0] eight_bit_timer,
  input wire logic [7:0] second_timer_count,
  input wire logic [7:0] second_timer_period,
  input wire logic sleep,
  output logic irq_request,
  output logic wake_request,
  output logic secondary_osc_run,
  output logic [15:0] count_value
);

  gt16_state_s s;
  gt16_state_s next_s;

  logic setup;
  logic access;
  logic mapped;
  logic wr;
  logic [31:0] rd;
  logic tick;
  logic run_ok;
  logic src_lvl;
  logic src_rise;
  logic gate_pre;
  logic active;
  logic act_rise;
  logic act_fall;
  logic inc;
  logic gate_fall;
  logic wr_gate;
  logic wr_cnt;

  always_comb
  begin
    next_s = s;
    // First stage feeds only the second stage
    next_s.meta = {low_freq_internal_osc, secondary_osc_clock,
                   ext_clock_pin, gate_input_pin};
    next_s.sync = s.meta;

    // Internal event pulses from the neighbouring timers
    next_s.t0_prev = eight_bit_timer;
    next_s.t2_prev = second_timer_count;
    next_s.t0_pulse = (s.t0_prev == GT16_WRAP8_FROM) &&
                      (eight_bit_timer == GT16_WRAP8_TO);
    next_s.t2_pulse = (second_timer_count != s.t2_prev) &&
                      (second_timer_count == second_timer_period);

    // Counter tick enable from the selected source
    next_s.div = s.div + 2'h1;
    next_s.ext_prev = s.oscen ? s.sync[2] : s.sync[1];
    next_s.lf_prev = s.sync[3];
    case (s.cs)
      GT16_CS_DIV4: tick = (s.div == GT16_DIV4_LAST);
      GT16_CS_SYS: tick = 1'b1;
      GT16_CS_EXT: tick = next_s.ext_prev & ~s.ext_prev;
      GT16_CS_LFOSC: tick = s.sync[3] & ~s.lf_prev;
      default: tick = 1'b0;
    endcase
    // Only the unsynchronised external mode keeps counting in sleep
    run_ok = ~sleep | (s.syncdis & (s.cs == GT16_CS_EXT));

    case (s.src)
      GT16_SRC_PIN: src_lvl = s.sync[0];
      GT16_SRC_WRAP8: src_lvl = s.t0_pulse;
      GT16_SRC_MATCH: src_lvl = s.t2_pulse;
      default: src_lvl = 1'b0;
    endcase
    src_rise = src_lvl & ~s.src_prev;
    next_s.src_prev = src_lvl;

    if (!s.tm || !s.on)
    begin
      next_s.tff = 1'b0;
    end
    else if (src_rise)
    begin
      next_s.tff = ~s.tff;
    end
    gate_pre = s.tm ? s.tff : src_lvl;
    active = s.pol ? gate_pre : ~gate_pre;
    act_rise = active & ~s.active_prev;
    act_fall = ~active & s.active_prev;
    next_s.active_prev = active;

    // Single-pulse sequencer; with toggle on this spans a full cycle
    case (s.sp)
      GT16_SP_IDLE: next_s.sp = GT16_SP_IDLE;
      GT16_SP_ARMED:
      begin
        if (act_rise)
        begin
          next_s.sp = GT16_SP_RUN;
        end
      end
      GT16_SP_RUN:
      begin
        if (act_fall)
        begin
          next_s.sp = GT16_SP_IDLE;
        end
      end
      default: next_s.sp = GT16_SP_IDLE;
    endcase

    // Sync resets low, so a high pin at reset may log one gate event
    // Status follows the gate whatever the gate enable says
    next_s.gval = s.spm ? (next_s.sp == GT16_SP_RUN) : active;
    gate_fall = s.gval & ~next_s.gval;

    inc = tick & run_ok & s.on & (~s.ge | s.gval);
    if (inc)
    begin
      next_s.count = s.count + 16'h0001;
    end

    // Bus slave: pready is raised in setup so access always takes one cycle
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable & s.rsp.pready;
    case (apb_req.paddr)
      GT16_OFF_CTRL, GT16_OFF_GATE, GT16_OFF_CNT_LO, GT16_OFF_CNT_HI,
      GT16_OFF_FLAGS, GT16_OFF_IEN, GT16_OFF_IRQCTL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    wr = access & apb_req.pwrite & mapped;
    wr_gate = wr & (apb_req.paddr == GT16_OFF_GATE);
    wr_cnt = wr & ((apb_req.paddr == GT16_OFF_CNT_LO) ||
                   (apb_req.paddr == GT16_OFF_CNT_HI));

    rd = 32'h0;
    case (apb_req.paddr)
      GT16_OFF_CTRL:
      begin
        rd[GT16_CTRL_CS +: 2] = s.cs;
        rd[GT16_CTRL_OSCEN] = s.oscen;
        rd[GT16_CTRL_SYNCDIS] = s.syncdis;
        rd[GT16_CTRL_ON] = s.on;
      end
      GT16_OFF_GATE:
      begin
        rd[GT16_GATE_EN] = s.ge;
        rd[GT16_GATE_POL] = s.pol;
        rd[GT16_GATE_TM] = s.tm;
        rd[GT16_GATE_SPM] = s.spm;
        rd[GT16_GATE_GO] = (s.sp != GT16_SP_IDLE);
        rd[GT16_GATE_VAL] = s.gval;
        rd[GT16_GATE_SRC +: 2] = s.src;
      end
      // Count is held in the bus clock domain; the two bytes are read separately and can tear
      GT16_OFF_CNT_LO: rd[7:0] = s.count[7:0];
      GT16_OFF_CNT_HI: rd[7:0] = s.count[15:8];
      GT16_OFF_FLAGS:
      begin
        rd[GT16_FLAG_GATE] = s.gate_f;
        rd[GT16_FLAG_ROLL] = s.roll_f;
      end
      GT16_OFF_IEN:
      begin
        rd[GT16_FLAG_GATE] = s.gate_ie;
        rd[GT16_FLAG_ROLL] = s.roll_ie;
      end
      GT16_OFF_IRQCTL:
      begin
        rd[GT16_IRQ_GIE] = s.global_irq_enable;
        rd[GT16_IRQ_PERIPHERAL_IRQ_ENABLE] = s.peripheral_irq_enable;
      end
      default: rd = 32'h0;
    endcase
    next_s.rsp.pready = setup;
    next_s.rsp.pslverr = setup & ~mapped;
    next_s.rsp.prdata = setup ? rd : 32'h0;

    if (wr)
    begin
      case (apb_req.paddr)
        GT16_OFF_CTRL:
        begin
          next_s.cs = apb_req.pwdata[GT16_CTRL_CS +: 2];
          next_s.oscen = apb_req.pwdata[GT16_CTRL_OSCEN];
          next_s.syncdis = apb_req.pwdata[GT16_CTRL_SYNCDIS];
          next_s.on = apb_req.pwdata[GT16_CTRL_ON];
        end
        GT16_OFF_GATE:
        begin
          next_s.ge = apb_req.pwdata[GT16_GATE_EN];
          next_s.pol = apb_req.pwdata[GT16_GATE_POL];
          next_s.tm = apb_req.pwdata[GT16_GATE_TM];
          next_s.spm = apb_req.pwdata[GT16_GATE_SPM];
          next_s.src = apb_req.pwdata[GT16_GATE_SRC +: 2];
          // Software set beats the hardware clear of the same cycle
          if (!apb_req.pwdata[GT16_GATE_GO])
          begin
            next_s.sp = GT16_SP_IDLE;
          end
          else if (next_s.sp == GT16_SP_IDLE)
          begin
            next_s.sp = GT16_SP_ARMED;
          end
        end
        // A write beats a coincident increment
        GT16_OFF_CNT_LO: next_s.count[7:0] = apb_req.pwdata[7:0];
        GT16_OFF_CNT_HI: next_s.count[15:8] = apb_req.pwdata[7:0];
        GT16_OFF_FLAGS:
        begin
          // Writing zero clears a flag, writing one leaves it
          next_s.gate_f = s.gate_f & apb_req.pwdata[GT16_FLAG_GATE];
          next_s.roll_f = s.roll_f & apb_req.pwdata[GT16_FLAG_ROLL];
        end
        GT16_OFF_IEN:
        begin
          next_s.gate_ie = apb_req.pwdata[GT16_FLAG_GATE];
          next_s.roll_ie = apb_req.pwdata[GT16_FLAG_ROLL];
        end
        GT16_OFF_IRQCTL:
        begin
          next_s.global_irq_enable = apb_req.pwdata[GT16_IRQ_GIE];
          next_s.peripheral_irq_enable = apb_req.pwdata[GT16_IRQ_PERIPHERAL_IRQ_ENABLE];
        end
        default: next_s.on = s.on;
      endcase
    end

    // Hardware sets come last so they win over a software clear
    if (gate_fall)
    begin
      next_s.gate_f = 1'b1;
    end
    if (inc && (s.count == GT16_COUNT_MAX))
    begin
      next_s.roll_f = 1'b1;
    end

    next_s.irq = next_s.global_irq_enable & next_s.peripheral_irq_enable &
                 ((next_s.roll_f & next_s.roll_ie & next_s.on) |
                  (next_s.gate_f & next_s.gate_ie));
    // Wake needs no global enable; that only decides the service call
    next_s.wake = sleep & next_s.on & next_s.roll_ie & next_s.peripheral_irq_enable &
                  next_s.roll_f;
    next_s.osc_run = next_s.oscen;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.sp <= GT16_SP_IDLE;
      s.count <= GT16_RST_COUNT;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign apb_rsp = s.rsp;
  assign irq_request = s.irq;
  assign wake_request = s.wake;
  assign secondary_osc_run = s.osc_run;
  assign count_value = s.count;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_off_holds_count: assert property (
    (!s.on && !wr_cnt) |=> (s.count == $past(s.count)))
    else $error("count moved while timer off");

  a_toggle_held_clear: assert property (
    (!s.tm) |=> !s.tff)
    else $error("toggle flip-flop not held clear");

  a_gate_blocks_count: assert property (
    (s.on && s.ge && !s.gval && !wr_cnt) |=> $stable(s.count))
    else $error("count moved with gate closed");

  a_rollover_sets_flag: assert property (
    (inc && s.count == 16'hffff && !wr_cnt) |=>
      (s.roll_f && s.count == 16'h0000))
    else $error("rollover did not wrap and flag");

  a_gate_fall_flag: assert property (
    (s.gval ##1 !s.gval) |-> s.gate_f)
    else $error("gate level fall missed");

  a_irq_needs_enables: assert property (
    irq_request |-> (s.global_irq_enable && s.peripheral_irq_enable))
    else $error("interrupt without global enables");

  a_sp_trailing_done: assert property (
    (s.sp == GT16_SP_RUN && act_fall && !wr_gate) |=>
      (s.sp == GT16_SP_IDLE) ##1 (s.sp == GT16_SP_IDLE || $past(wr_gate)))
    else $error("single pulse not closed on trailing edge");

  a_sleep_stops_count: assert property (
    (sleep && !(s.syncdis && s.cs == GT16_CS_EXT) && !wr_cnt) |=>
      (s.count == $past(s.count)))
    else $error("count moved in sleep");

  a_wrap8_pulse: assert property (
    (eight_bit_timer == 8'hff ##1 eight_bit_timer == 8'h00) |=> s.t0_pulse)
    else $error("eight-bit wrap pulse missing");

  a_off_clears_toggle: assert property (
    (!s.on) |=> !s.tff)
    else $error("toggle flip-flop not cleared while off");

  a_sp_idle_holds: assert property (
    (s.on && s.ge && s.spm && $past(s.spm) && s.sp == GT16_SP_IDLE &&
     !wr_cnt) |=> $stable(s.count))
    else $error("count moved after single pulse closed");

  a_arm_to_run: assert property (
    (s.sp == GT16_SP_ARMED && act_rise && !wr_gate) |=>
      (s.sp == GT16_SP_RUN))
    else $error("armed capture missed the gate edge");

  a_toggle_flips: assert property (
    (s.tm && s.on && src_rise) |=> (s.tff != $past(s.tff)))
    else $error("toggle flip-flop did not flip");

  a_match_pulse: assert property (
    (second_timer_count != $past(second_timer_count) &&
     second_timer_count == second_timer_period) |=> s.t2_pulse)
    else $error("period match pulse missing");

  a_div4_tick: assert property (
    (s.cs == GT16_CS_DIV4 && s.div != GT16_DIV4_LAST && !wr_cnt) |=>
      $stable(s.count))
    else $error("count moved between divided ticks");

  a_lf_tick: assert property (
    (s.cs == GT16_CS_LFOSC && !(s.sync[3] && !s.lf_prev) && !wr_cnt) |=>
      $stable(s.count))
    else $error("count moved without an oscillator edge");

  a_wake_in_sleep: assert property (
    wake_request |-> $past(sleep))
    else $error("wake raised outside sleep");

  a_osc_in_sleep: assert property (
    (sleep && s.oscen) |-> secondary_osc_run)
    else $error("secondary oscillator stopped in sleep");

  a_roll_irq_path: assert property (
    (irq_request && !s.gate_f) |-> (s.on && s.roll_ie && s.roll_f))
    else $error("rollover interrupt without its enables");

  a_gate_irq_path: assert property (
    (irq_request && !s.roll_f) |-> (s.gate_ie && s.gate_f))
    else $error("gate interrupt without its enable");

  c_rollover: cover property (inc && s.count == 16'hffff);
  c_sp_capture: cover property (
    (s.sp == GT16_SP_ARMED) ##1 (s.sp == GT16_SP_RUN) ##[1:200]
    (s.sp == GT16_SP_IDLE));
  c_gate_event: cover property (gate_fall && s.gate_ie);
  c_wake: cover property (wake_request);
  c_sp_toggle: cover property (s.tm && s.spm && s.sp == GT16_SP_RUN);

endmodule
`default_nettype wire

// ---- gt16_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module gt16_far_side
  import gt16_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic gate_level,
  output logic gate_input_pin,
  output logic [7:0] eight_bit_timer,
  output logic [7:0] second_timer_count,
  output logic [7:0] second_timer_period,
  output logic ext_clock_pin,
  output logic secondary_osc_clock,
  output logic low_freq_internal_osc
);
  logic [4:0] div;
  assign gate_input_pin = gate_level;
  assign second_timer_period = 8'h3f;
  // One divider feeds all slow clocks; ext pin rises every 8 pclk
  assign ext_clock_pin = div[2];
  assign secondary_osc_clock = div[3];
  assign low_freq_internal_osc = div[4];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div <= 5'h00;
      eight_bit_timer <= 8'h00;
      second_timer_count <= 8'h00;
    end
    else
    begin
      div <= div + 5'h01;
      eight_bit_timer <= eight_bit_timer + 8'h01;
      if (second_timer_count == second_timer_period)
        second_timer_count <= 8'h00;
      else
        second_timer_count <= second_timer_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
  import gt16_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic gate = 1'b1;
  logic sleep_i = 1'b0;
  gt16_apb_req_s req = '0;
  gt16_apb_rsp_s rsp;
  logic g_pin, ext_ck, sosc_ck, lf_ck, irq, wake, osc_run;
  logic [7:0] t0, t2c, t2p;
  logic [15:0] cnt, snap;
  logic [31:0] rdat;
  logic perr;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  gt16_far_side far
  (
    .pclk(pclk), .presetn(presetn), .gate_level(gate),
    .gate_input_pin(g_pin), .eight_bit_timer(t0),
    .second_timer_count(t2c), .second_timer_period(t2p),
    .ext_clock_pin(ext_ck), .secondary_osc_clock(sosc_ck),
    .low_freq_internal_osc(lf_ck)
  );
  gt16_gate_timer dut
  (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .gate_input_pin(g_pin), .ext_clock_pin(ext_ck),
    .secondary_osc_clock(sosc_ck), .low_freq_internal_osc(lf_ck),
    .eight_bit_timer(t0), .second_timer_count(t2c),
    .second_timer_period(t2p), .sleep(sleep_i), .irq_request(irq),
    .wake_request(wake), .secondary_osc_run(osc_run),
    .count_value(cnt)
  );

  initial
    forever #2.5 pclk = ~pclk;

  task automatic conclude();
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs about 2400 cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, {24'h000000, d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1)
      @(posedge pclk);
    rdat = rsp.prdata;
    perr = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdat, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic t_roll();
    apb(1'b0, 8'h20, 8'h00);
    chk({perr, rdat[30:0]}, 32'h80000000);
    wr(8'h08, 8'hfe);
    wr(8'h0c, 8'hff);
    rd(8'h08, 32'hfe);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h01);
    wr(8'h18, 8'hc0);
    wr(8'h00, 8'h41);
    tick(4);
    chk(irq, 1'b1);
    wr(8'h00, 8'h40);
    tick(1);
    snap = cnt;
    chk(snap[15:4], 12'h000);
    rd(8'h10, 32'h01);
    chk(irq, 1'b0);
    chk(cnt, snap);
    wr(8'h18, 8'h00);
  endtask

  task automatic t_gate();
    gate <= 1'b0;
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h04, 8'hc0);
    wr(8'h00, 8'h41);
    tick(8);
    chk(cnt, 16'h0000);
    rd(8'h04, 32'hc0);
    gate <= 1'b1;
    tick(8);
    chk(cnt != 16'h0000, 1'b1);
    wr(8'h04, 8'h80);
    tick(4);
    snap = cnt;
    tick(8);
    chk(cnt, snap);
    wr(8'h04, 8'h40);
    rd(8'h04, 32'h44);
    wr(8'h10, 8'h00);
    gate <= 1'b0;
    tick(6);
    rd(8'h10, 32'h80);
    rd(8'h04, 32'h40);
    wr(8'h18, 8'hc0);
    tick(1);
    chk(irq, 1'b0);
    wr(8'h14, 8'h81);
    tick(1);
    chk(irq, 1'b1);
    wr(8'h18, 8'h00);
    wr(8'h00, 8'h40);
  endtask

  task automatic t_src();
    for (int s = 1; s < 4; s++)
    begin
      wr(8'h04, 8'h40 | 8'(s));
      wr(8'h10, 8'h00);
      tick(600);
      rd(8'h10, (s == 3) ? 32'h0 : 32'h80);
    end
  endtask

  task automatic t_spm();
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h04, 8'hd0);
    wr(8'h04, 8'hd8);
    wr(8'h00, 8'h41);
    tick(8);
    chk(cnt, 16'h0000);
    gate <= 1'b1;
    tick(10);
    gate <= 1'b0;
    tick(8);
    rd(8'h04, 32'hd0);
    snap = cnt;
    chk(snap > 16'h0004, 1'b1);
    gate <= 1'b1;
    tick(10);
    chk(cnt, snap);
    gate <= 1'b0;
    wr(8'h04, 8'h00);
  endtask

  task automatic t_tog();
    wr(8'h04, 8'hc0);
    wr(8'h04, 8'he0);
    gate <= 1'b1;
    tick(4);
    gate <= 1'b0;
    tick(6);
    rd(8'h04, 32'he4);
    wr(8'h04, 8'hc0);
    rd(8'h04, 32'hc0);
    wr(8'h04, 8'he0);
    rd(8'h04, 32'he0);
    wr(8'h04, 8'hf0);
    wr(8'h04, 8'hf8);
    gate <= 1'b1;
    tick(4);
    gate <= 1'b0;
    tick(6);
    rd(8'h04, 32'hfc);
    gate <= 1'b1;
    tick(6);
    rd(8'h04, 32'hf0);
    gate <= 1'b0;
    wr(8'h04, 8'hc0);
  endtask

  task automatic t_clk();
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h00, 8'h01);
    tick(40);
    wr(8'h00, 8'h00);
    tick(1);
    chk((cnt > 16'h0005) && (cnt < 16'h0014), 1'b1);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h00, 8'hc1);
    tick(100);
    wr(8'h00, 8'hc0);
    tick(1);
    chk((cnt > 16'h0001) && (cnt < 16'h0006), 1'b1);
  endtask

  task automatic t_sleep();
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h40);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h00);
    sleep_i <= 1'b1;
    wr(8'h00, 8'h41);
    tick(10);
    chk(cnt, 16'h0000);
    wr(8'h00, 8'h80);
    wr(8'h08, 8'hf8);
    wr(8'h0c, 8'hff);
    wr(8'h10, 8'h00);
    wr(8'h18, 8'h40);
    wr(8'h00, 8'h85);
    tick(20);
    chk(cnt != 16'hfff8, 1'b1);
    tick(100);
    chk(wake, 1'b1);
    chk(irq, 1'b0);
    wr(8'h00, 8'h8c);
    tick(2);
    chk(osc_run, 1'b1);
    sleep_i <= 1'b0;
  endtask

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_roll();
    t_gate();
    t_src();
    t_spm();
    wr(8'h00, 8'h41);
    t_tog();
    t_clk();
    t_sleep();
    conclude();
  end
endmodule
`default_nettype wire
